// ==== ckpd_ctrl.sv ====
// Per-rank CKE power-down controller with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none

module ckpd_ctrl (
  // Clock, reset, enable
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   clk_en_in,
  // Avalon-MM slave
  input  wire logic [15:0]            avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output var  logic [31:0]            avs_readdata_out,
  output var  logic                   avs_waitrequest_out,
  // Scheduler and power manager
  input  wire ckpd_pkg::ckpd_rank_in_t rank_in,
  input  wire ckpd_pkg::ckpd_sys_in_t  sys_in,
  input  wire logic [3:0]             rx_valid_in,
  // Memory pins per rank
  output var  logic [3:0]             cke_out,
  output var  logic [3:0]             cke_oe_n_out,
  output var  logic [3:0]             cs_oe_n_out,
  output var  logic [3:0]             io_drv_en_out,
  output var  logic [3:0]             io_rx_en_out,
  output var  logic [3:0]             rx_valid_out,
  // Command requests and status to the scheduler
  output var  logic [3:0]             pre_all_req_out,
  output var  logic [3:0]             sr_entry_out,
  output var  logic [3:0]             sr_exit_out,
  output var  logic [3:0]             pages_closed_out,
  output var  logic [3:0]             cmd_ok_out,
  output var  logic [3:0]             xfer_ok_out,
  output var  logic                   refresh_go_out,
  output var  logic                   io_dll_off_out
);

  logic [7:0]  idle_cfg_reg;
  logic [2:0]  policy_reg;
  logic        sdll_en_reg;
  logic        init_done_reg;
  logic [3:0]  pop_reg;
  logic [3:0]  tri_en_reg;
  logic [7:0]  dll_wake_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic        dll_off_reg;
  logic [7:0]  dll_wait_reg;

  ckpd_pkg::ckpd_state_t st_reg   [ckpd_pkg::RANKS];
  ckpd_pkg::ckpd_tgt_t   tgt_reg  [ckpd_pkg::RANKS];
  logic [7:0]            idle_reg [ckpd_pkg::RANKS];
  logic [4:0]            xcnt_reg [ckpd_pkg::RANKS];
  logic [3:0]            pd_open_reg;
  logic [3:0]            pd_dll_reg;
  logic [3:0]            conv_reg;

  ckpd_pkg::ckpd_policy_t pol;
  logic        dyn_en;
  logic [3:0]  absent;
  logic [3:0]  idle_exp;
  logic        sr_want;
  logic        all_up;
  logic        all_low;
  logic        wake_any;
  logic        io_ready;
  logic        acc;
  logic        wr;
  logic [31:0] rd_mux;

  function automatic logic asleep(input ckpd_pkg::ckpd_state_t s);
    asleep = (s == ckpd_pkg::ST_PD) || (s == ckpd_pkg::ST_SR);
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  // Illegal policy codes fall back to no power-down
  always_comb begin
    pol = ckpd_pkg::ckpd_policy_t'(policy_reg);
    dyn_en = (policy_reg >= 3'h1) && (policy_reg <= 3'h5);
  end

  // Tri-state only where software both allows it and marks the rank empty
  assign absent = tri_en_reg & ~pop_reg;
  assign sr_want = sys_in.suspend_req ||
                   (sys_in.deep_idle && ~|rank_in.txn_pending);
  assign io_ready = !dll_off_reg && (dll_wait_reg == 8'h00);

  always_comb begin
    all_up   = 1'b1;
    all_low  = ~&absent;
    wake_any = 1'b0;
    for (int r = 0; r < ckpd_pkg::RANKS; r++) begin
      idle_exp[r] = idle_reg[r] >= idle_cfg_reg;
      if (!absent[r]) begin
        if (st_reg[r] != ckpd_pkg::ST_UP)
          all_up = 1'b0;
        if (!asleep(st_reg[r]))
          all_low = 1'b0;
        if (st_reg[r] == ckpd_pkg::ST_EXIT)
          wake_any = 1'b1;
      end
    end
  end

  // Avalon slave: one wait cycle, then a single-cycle answer
  assign acc = (avs_read_in || avs_write_in) && wait_reg;
  assign wr  = avs_write_in && wait_reg && avs_byteenable_in[0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address_in, ckpd_pkg::IDLE_CFG_ADDR)) begin
      rd_mux[7:0] = idle_cfg_reg;
    end else if (hit(avs_address_in, ckpd_pkg::CTRL_ADDR)) begin
      rd_mux[ckpd_pkg::CTRL_POL_LSB +: 3] = policy_reg;
      rd_mux[ckpd_pkg::CTRL_SDLL_BIT] = sdll_en_reg;
    end else if (hit(avs_address_in, ckpd_pkg::RANK_CFG_ADDR)) begin
      rd_mux[ckpd_pkg::RCFG_POP_LSB +: 4] = pop_reg;
      rd_mux[ckpd_pkg::RCFG_TRI_LSB +: 4] = tri_en_reg;
    end else if (hit(avs_address_in, ckpd_pkg::DLL_WAKE_ADDR)) begin
      rd_mux[7:0] = dll_wake_reg;
    end else if (hit(avs_address_in, ckpd_pkg::STATUS_ADDR)) begin
      for (int r = 0; r < ckpd_pkg::RANKS; r++)
        rd_mux[r*4 +: 4] = {pd_open_reg[r], st_reg[r]};
      rd_mux[ckpd_pkg::STAT_DLL_BIT]  = dll_off_reg;
      rd_mux[ckpd_pkg::STAT_INIT_BIT] = init_done_reg;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en_in) begin
      wait_reg <= !acc;
      if (acc)
        rdata_reg <= avs_read_in ? rd_mux : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      idle_cfg_reg  <= ckpd_pkg::IDLE_CFG_RST;
      policy_reg    <= ckpd_pkg::POLICY_RST;
      sdll_en_reg   <= 1'b0;
      init_done_reg <= 1'b0;
      pop_reg       <= ckpd_pkg::POP_RST;
      tri_en_reg    <= ckpd_pkg::TRI_RST;
      dll_wake_reg  <= ckpd_pkg::DLL_WAKE_RST;
    end else if (clk_en_in && wr) begin
      if (hit(avs_address_in, ckpd_pkg::IDLE_CFG_ADDR))
        idle_cfg_reg <= avs_writedata_in[7:0];
      if (hit(avs_address_in, ckpd_pkg::CTRL_ADDR)) begin
        policy_reg    <= avs_writedata_in[ckpd_pkg::CTRL_POL_LSB +: 3];
        sdll_en_reg   <= avs_writedata_in[ckpd_pkg::CTRL_SDLL_BIT];
        init_done_reg <= 1'b1;
      end
      if (hit(avs_address_in, ckpd_pkg::RANK_CFG_ADDR)) begin
        pop_reg    <= avs_writedata_in[ckpd_pkg::RCFG_POP_LSB +: 4];
        tri_en_reg <= avs_writedata_in[ckpd_pkg::RCFG_TRI_LSB +: 4];
      end
      if (hit(avs_address_in, ckpd_pkg::DLL_WAKE_ADDR))
        dll_wake_reg <= avs_writedata_in[7:0];
    end
  end

  // I/O slave DLLs: off while every present rank sleeps, timed relock
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dll_off_reg  <= 1'b0;
      dll_wait_reg <= 8'h00;
    end else if (clk_en_in) begin
      if (!dll_off_reg && sdll_en_reg && all_low) begin
        dll_off_reg <= 1'b1;
      end else if (dll_off_reg && (wake_any || !sdll_en_reg)) begin
        dll_off_reg  <= 1'b0;
        dll_wait_reg <= dll_wake_reg;
      end else if (dll_wait_reg != 8'h00) begin
        dll_wait_reg <= dll_wait_reg - 8'h01;
      end
    end
  end

  // Idle counters: restart on arrival, forced expired after refresh
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int r = 0; r < ckpd_pkg::RANKS; r++)
        idle_reg[r] <= 8'h00;
    end else if (clk_en_in) begin
      for (int r = 0; r < ckpd_pkg::RANKS; r++) begin
        if (rank_in.txn_arrive[r] || st_reg[r] != ckpd_pkg::ST_UP)
          idle_reg[r] <= 8'h00;
        else if (sys_in.refresh_done && dyn_en)
          idle_reg[r] <= 8'hff;
        else if (!idle_exp[r])
          idle_reg[r] <= idle_reg[r] + 8'h01;
      end
    end
  end

  // Per-rank power state machines
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int r = 0; r < ckpd_pkg::RANKS; r++) begin
        st_reg[r]   <= ckpd_pkg::ST_UP;
        tgt_reg[r]  <= ckpd_pkg::TGT_PD;
        xcnt_reg[r] <= 5'h00;
      end
      pd_open_reg      <= 4'h0;
      pd_dll_reg       <= 4'h0;
      conv_reg         <= 4'h0;
      pre_all_req_out  <= 4'h0;
      sr_entry_out     <= 4'h0;
      sr_exit_out      <= 4'h0;
      pages_closed_out <= 4'h0;
    end else if (clk_en_in) begin
      pre_all_req_out  <= 4'h0;
      sr_entry_out     <= 4'h0;
      sr_exit_out      <= 4'h0;
      pages_closed_out <= 4'h0;
      for (int r = 0; r < ckpd_pkg::RANKS; r++) begin
        if (absent[r] || !init_done_reg) begin
          st_reg[r] <= ckpd_pkg::ST_UP;
        end else begin
          unique case (st_reg[r])
            ckpd_pkg::ST_UP: begin
              if (sr_want && sys_in.drained && !sys_in.refresh_req) begin
                if (rank_in.bank_open[r]) begin
                  pre_all_req_out[r] <= 1'b1;
                  tgt_reg[r] <= ckpd_pkg::TGT_SR;
                  st_reg[r]  <= ckpd_pkg::ST_PRE;
                end else begin
                  sr_entry_out[r] <= 1'b1;
                  st_reg[r] <= ckpd_pkg::ST_SR;
                end
              end else if (dyn_en && idle_exp[r] && !sr_want &&
                           !rank_in.txn_pending[r] &&
                           !sys_in.refresh_req) begin
                if (pol == ckpd_pkg::POL_OPEN ||
                    pol == ckpd_pkg::POL_OPEN_CLS ||
                    pol == ckpd_pkg::POL_OPEN_DLL) begin
                  st_reg[r]      <= ckpd_pkg::ST_PD;
                  pd_open_reg[r] <= rank_in.bank_open[r];
                  pd_dll_reg[r]  <= 1'b0;
                end else if (rank_in.bank_open[r]) begin
                  pre_all_req_out[r] <= 1'b1;
                  tgt_reg[r] <= (pol == ckpd_pkg::POL_DLLOFF) ?
                                ckpd_pkg::TGT_DLL : ckpd_pkg::TGT_PD;
                  st_reg[r]  <= ckpd_pkg::ST_PRE;
                end else begin
                  st_reg[r]      <= ckpd_pkg::ST_PD;
                  pd_open_reg[r] <= 1'b0;
                  pd_dll_reg[r]  <= (pol == ckpd_pkg::POL_DLLOFF);
                end
              end
            end
            ckpd_pkg::ST_PRE: begin
              // Hold CKE high until pre_done reports the precharge-all complete
              if (rank_in.pre_done[r]) begin
                if (tgt_reg[r] == ckpd_pkg::TGT_SR) begin
                  sr_entry_out[r] <= 1'b1;
                  st_reg[r] <= ckpd_pkg::ST_SR;
                end else begin
                  st_reg[r]      <= ckpd_pkg::ST_PD;
                  pd_open_reg[r] <= 1'b0;
                  pd_dll_reg[r]  <= (tgt_reg[r] == ckpd_pkg::TGT_DLL);
                end
              end
            end
            ckpd_pkg::ST_PD: begin
              xcnt_reg[r] <= 5'h00;
              if (rank_in.txn_pending[r] || sys_in.refresh_req ||
                  sr_want) begin
                st_reg[r]   <= ckpd_pkg::ST_EXIT;
                conv_reg[r] <= 1'b0;
              end else if (pd_open_reg[r] && rank_in.pages_expired[r] &&
                           (pol == ckpd_pkg::POL_OPEN_CLS ||
                            pol == ckpd_pkg::POL_OPEN_DLL)) begin
                st_reg[r]   <= ckpd_pkg::ST_EXIT;
                conv_reg[r] <= 1'b1;
              end
            end
            ckpd_pkg::ST_EXIT: begin
              // Exit timing only starts once the I/O DLLs are locked
              if (io_ready && xcnt_reg[r] != 5'h1f)
                xcnt_reg[r] <= xcnt_reg[r] + 5'h01;
              if (conv_reg[r] && xcnt_reg[r] >= ckpd_pkg::XP_CYC) begin
                pre_all_req_out[r] <= 1'b1;
                conv_reg[r] <= 1'b0;
                tgt_reg[r]  <= (pol == ckpd_pkg::POL_OPEN_DLL) ?
                               ckpd_pkg::TGT_DLL : ckpd_pkg::TGT_PD;
                st_reg[r]   <= ckpd_pkg::ST_PRE;
              end else if (!conv_reg[r] &&
                           xcnt_reg[r] >= (pd_dll_reg[r] ?
                           ckpd_pkg::XPDLL_CYC : ckpd_pkg::XP_CYC)) begin
                st_reg[r] <= ckpd_pkg::ST_UP;
                pages_closed_out[r] <= !pd_open_reg[r];
              end
            end
            ckpd_pkg::ST_SR: begin
              xcnt_reg[r] <= 5'h00;
              if (!sr_want) begin
                sr_exit_out[r] <= 1'b1;
                st_reg[r]      <= ckpd_pkg::ST_EXIT;
                pd_open_reg[r] <= 1'b0;
                pd_dll_reg[r]  <= 1'b1;
                conv_reg[r]    <= 1'b0;
              end
            end
            default: st_reg[r] <= ckpd_pkg::ST_UP;
          endcase
        end
      end
    end
  end

  // Pin side outputs, all registered
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cke_out       <= 4'h0;
      cke_oe_n_out  <= 4'h0;
      cs_oe_n_out   <= 4'h0;
      io_drv_en_out <= 4'hf;
      io_rx_en_out  <= 4'hf;
      rx_valid_out  <= 4'h0;
      cmd_ok_out    <= 4'h0;
      xfer_ok_out   <= 4'h0;
    end else if (clk_en_in) begin
      cke_oe_n_out  <= absent;
      cs_oe_n_out   <= absent;
      io_drv_en_out <= ~absent;
      io_rx_en_out  <= ~absent;
      rx_valid_out  <= rx_valid_in & ~absent;
      for (int r = 0; r < ckpd_pkg::RANKS; r++) begin
        cke_out[r] <= init_done_reg && !absent[r] &&
                      (st_reg[r] == ckpd_pkg::ST_UP ||
                       st_reg[r] == ckpd_pkg::ST_PRE ||
                       (st_reg[r] == ckpd_pkg::ST_EXIT &&
                        io_ready));
        cmd_ok_out[r] <= init_done_reg && !absent[r] &&
                         (st_reg[r] == ckpd_pkg::ST_UP ||
                          st_reg[r] == ckpd_pkg::ST_PRE ||
                          (st_reg[r] == ckpd_pkg::ST_EXIT &&
                           xcnt_reg[r] >= ckpd_pkg::XP_CYC));
        xfer_ok_out[r] <= init_done_reg && !absent[r] &&
                          st_reg[r] == ckpd_pkg::ST_UP;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      refresh_go_out <= 1'b0;
      io_dll_off_out <= 1'b0;
    end else if (clk_en_in) begin
      refresh_go_out <= sys_in.refresh_req && all_up &&
                        init_done_reg;
      io_dll_off_out <= dll_off_reg;
    end
  end

  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = wait_reg;

endmodule

`default_nettype wire

// ==== ckpd_pkg.sv ====
// Package: register map, constants and types of the rank CKE power block
package ckpd_pkg;

  localparam int          RANKS          = 4;

  // Register byte addresses
  localparam logic [15:0] IDLE_CFG_ADDR  = 16'h4cb0;
  localparam logic [15:0] CTRL_ADDR      = 16'h4cb4;
  localparam logic [15:0] RANK_CFG_ADDR  = 16'h4cb8;
  localparam logic [15:0] DLL_WAKE_ADDR  = 16'h4cbc;
  localparam logic [15:0] STATUS_ADDR    = 16'h4cc0;

  // Field positions
  localparam int          CTRL_POL_LSB   = 0;
  localparam int          CTRL_SDLL_BIT  = 4;
  localparam int          RCFG_POP_LSB   = 0;
  localparam int          RCFG_TRI_LSB   = 4;
  localparam int          STAT_DLL_BIT   = 16;
  localparam int          STAT_INIT_BIT  = 17;

  // Reset values
  localparam logic [7:0]  IDLE_CFG_RST   = 8'h0f;
  localparam logic [2:0]  POLICY_RST     = 3'h0;
  localparam logic [3:0]  POP_RST        = 4'hf;
  localparam logic [3:0]  TRI_RST        = 4'h0;
  localparam logic [7:0]  DLL_WAKE_RST   = 8'h08;

  // Exit delays in controller cycles
  localparam logic [4:0]  XP_CYC         = 5'h03;
  localparam logic [4:0]  XPDLL_CYC      = 5'h14;

  typedef enum logic [2:0] {
    POL_NONE      = 3'h0,
    POL_OPEN      = 3'h1,
    POL_CLOSED    = 3'h2,
    POL_DLLOFF    = 3'h3,
    POL_OPEN_CLS  = 3'h4,
    POL_OPEN_DLL  = 3'h5
  } ckpd_policy_t;

  typedef enum logic [2:0] {
    ST_UP   = 3'h0,
    ST_PRE  = 3'h1,
    ST_PD   = 3'h2,
    ST_EXIT = 3'h3,
    ST_SR   = 3'h4
  } ckpd_state_t;

  typedef enum logic [1:0] {
    TGT_PD  = 2'h0,
    TGT_DLL = 2'h1,
    TGT_SR  = 2'h2
  } ckpd_tgt_t;

  // Per-rank status from the scheduler, one bit per rank
  typedef struct packed {
    logic [3:0] txn_arrive;
    logic [3:0] txn_pending;
    logic [3:0] bank_open;
    logic [3:0] pages_expired;
    logic [3:0] pre_done;
  } ckpd_rank_in_t;

  // Channel-wide requests from the power manager and refresh engine
  typedef struct packed {
    logic refresh_req;
    logic refresh_done;
    logic suspend_req;
    logic deep_idle;
    logic drained;
  } ckpd_sys_in_t;

endpackage

// ==== ckpd_ctrl_checker.sv ====
// Concurrent checks on the rank CKE power block ports
`timescale 1ns/1ps
`default_nettype none
module ckpd_checker (
  // Clock, reset and register bus
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic        avs_waitrequest_out,
  // Rank pins and status
  input  wire logic [3:0]  cke_out,
  input  wire logic [3:0]  cke_oe_n_out,
  input  wire logic [3:0]  cs_oe_n_out,
  input  wire logic [3:0]  io_rx_en_out,
  input  wire logic [3:0]  rx_valid_out,
  input  wire logic [3:0]  pre_all_req_out,
  input  wire logic [3:0]  cmd_ok_out,
  input  wire logic [3:0]  xfer_ok_out,
  input  wire logic        refresh_go_out,
  input  wire logic        io_dll_off_out
);
  logic init_seen_reg;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Tracks the first accepted control write, which releases CKE
  always_ff @(posedge core_clk_in) begin
    if (rst_in)
      init_seen_reg <= 1'b0;
    else if (avs_write_in && avs_waitrequest_out && avs_byteenable_in[0]
             && avs_address_in == ckpd_pkg::CTRL_ADDR)
      init_seen_reg <= 1'b1;
  end
  sequence s_wake0;
    $rose(cke_out[0]) && !cmd_ok_out[0];
  endsequence
  chk_cke_held: assert property (
    !init_seen_reg |-> cke_out == 4'h0) else $error("cke before init");
  chk_reset_driven: assert property (
    $fell(rst_in) |-> (cke_oe_n_out | cs_oe_n_out) == 4'h0)
    else $error("rank not driven after reset");
  chk_tri_pair: assert property (
    cke_oe_n_out == cs_oe_n_out) else $error("cke and cs enables differ");
  chk_absent_quiet: assert property (
    (cke_oe_n_out & (io_rx_en_out | rx_valid_out)) == 4'h0)
    else $error("absent rank input path live");
  chk_bus_answer: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer timing");
  chk_pre_pulse: assert property (
    |pre_all_req_out |=> (pre_all_req_out & $past(pre_all_req_out)) == 4'h0)
    else $error("precharge request not a pulse");
  chk_relock_wait: assert property (
    s_wake0 |-> !xfer_ok_out[0] [*3]) else $error("data too soon on exit");
  chk_xfer_order: assert property (
    (xfer_ok_out & ~(cmd_ok_out & cke_out)) == 4'h0)
    else $error("data allowed before commands");
  chk_refresh_up: assert property (
    refresh_go_out |-> (cke_out | cke_oe_n_out) == 4'hf)
    else $error("refresh with rank down");
  chk_dll_sleep: assert property (
    io_dll_off_out |-> (cke_out & ~cke_oe_n_out) == 4'h0)
    else $error("io dll off with rank awake");
endmodule
bind ckpd_ctrl ckpd_checker u_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out), .cke_out(cke_out),
  .cke_oe_n_out(cke_oe_n_out), .cs_oe_n_out(cs_oe_n_out),
  .io_rx_en_out(io_rx_en_out), .rx_valid_out(rx_valid_out),
  .pre_all_req_out(pre_all_req_out), .cmd_ok_out(cmd_ok_out),
  .xfer_ok_out(xfer_ok_out), .refresh_go_out(refresh_go_out),
  .io_dll_off_out(io_dll_off_out));
`default_nettype wire

// ==== ckpd_dram_model.sv ====
// Behavioural model of the memory ranks behind the controller
`timescale 1ns/1ps
`default_nettype none
module ckpd_dram_model (
  // Clock and bench controls
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] act_in,
  input  wire logic       slow_in,
  // Controller requests
  input  wire logic [3:0] pre_all_req_in,
  // Bank status back to the scheduler
  output var  logic [3:0] bank_open_out,
  output var  logic [3:0] pre_done_out
);
  int cnt [4];
  always_ff @(posedge core_clk_in) begin
    for (int r = 0; r < 4; r++) begin
      pre_done_out[r] <= !rst_in && cnt[r] == 1;
      // Pages survive power-down; only reset or a completing precharge closes them
      if (rst_in || cnt[r] == 1)
        bank_open_out[r] <= 1'b0;
      else if (act_in[r])
        bank_open_out[r] <= 1'b1;
      if (rst_in)
        cnt[r] <= 0;
      else if (pre_all_req_in[r])
        cnt[r] <= slow_in ? 9 : 2;
      else if (cnt[r] != 0)
        cnt[r] <= cnt[r] - 1;
    end
  end
endmodule
`default_nettype wire

// ==== ckpd_ctrl_tb.sv ====
// Self-checking bench for the rank CKE power block
`timescale 1ns/1ps
`default_nettype none
module ckpd_ctrl_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd, wr, waitreq, ref_req, ref_done, susp, deep, drained;
  logic        slow, ref_go, dll_off;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  arrive, pend, pexp, act, rxv, bank_open, pre_done;
  logic [3:0]  cke, cke_oe_n, cs_oe_n, drv_en, rx_en, rx_vo, pre_req;
  logic [3:0]  sr_in, sr_ex, pg_cl, cmd_ok, xfer_ok;
  logic [6:0]  watch;
  logic [31:0] mdl [logic [15:0]];
  logic [31:0] msk [logic [15:0]];
  int          err_count = 0, num_checks = 0;
  int          pre_cnt = 0, pc_cnt = 0, sr_cnt = 0, ex_cnt = 0;
  ckpd_pkg::ckpd_rank_in_t rank_s;
  ckpd_pkg::ckpd_sys_in_t  sys_s;
  assign rank_s = {arrive, pend, bank_open, pexp, pre_done};
  assign sys_s  = {ref_req, ref_done, susp, deep, drained};
  assign watch  = {dll_off, ref_go, xfer_ok[0], cke};
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    pre_cnt += pre_req[0];
    pc_cnt += pg_cl[0];
    sr_cnt += $countones(sr_in);
    ex_cnt += $countones(sr_ex);
  end
  ckpd_ctrl DUT (
    .core_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'h1),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .rank_in(rank_s), .sys_in(sys_s), .rx_valid_in(rxv),
    .cke_out(cke), .cke_oe_n_out(cke_oe_n), .cs_oe_n_out(cs_oe_n),
    .io_drv_en_out(drv_en), .io_rx_en_out(rx_en), .rx_valid_out(rx_vo),
    .pre_all_req_out(pre_req), .sr_entry_out(sr_in), .sr_exit_out(sr_ex),
    .pages_closed_out(pg_cl), .cmd_ok_out(cmd_ok), .xfer_ok_out(xfer_ok),
    .refresh_go_out(ref_go), .io_dll_off_out(dll_off));
  ckpd_dram_model u_ranks (
    .core_clk_in(clk), .rst_in(rst), .act_in(act), .slow_in(slow),
    .pre_all_req_in(pre_req), .bank_open_out(bank_open),
    .pre_done_out(pre_done));
  task automatic check(input logic [31:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    check(32'h0, 32'h1, msg);
    complete_run();
  endtask
  // Holds the request until waitrequest is seen low, then lets an edge pass
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) fail("bus timeout");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (w && msk.exists(a)) mdl[a] = d & msk[a];
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [15:0] a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, msk.exists(a) ? mdl[a] : 32'h0, "register readback");
  endtask
  task automatic wait_bit(input int i, input logic v, input int lim,
                          output int n);
    n = 0;
    while (watch[i] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic need(input int i, input logic v);
    int n;
    wait_bit(i, v, 600, n);
    if (n >= 600) fail("wait timeout");
  endtask
  initial begin
    int n, p, idle, pr0, pc0, sr0;
    logic [31:0] q;
    {rd, wr, ref_req, ref_done, susp, deep, drained, slow} = '0;
    {arrive, pend, pexp, act, rxv, addr, wdata} = '0;
    void'($urandom(33407));
    msk[ckpd_pkg::IDLE_CFG_ADDR] = 32'hff;
    msk[ckpd_pkg::CTRL_ADDR] = 32'h17;
    msk[ckpd_pkg::RANK_CFG_ADDR] = 32'hff;
    msk[ckpd_pkg::DLL_WAKE_ADDR] = 32'hff;
    mdl[ckpd_pkg::IDLE_CFG_ADDR] = 32'(ckpd_pkg::IDLE_CFG_RST);
    mdl[ckpd_pkg::CTRL_ADDR] = 32'(ckpd_pkg::POLICY_RST);
    mdl[ckpd_pkg::RANK_CFG_ADDR] = {24'h0, ckpd_pkg::TRI_RST,
                                    ckpd_pkg::POP_RST};
    mdl[ckpd_pkg::DLL_WAKE_ADDR] = 32'(ckpd_pkg::DLL_WAKE_RST);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (msk[a]) rdchk(a);
    rdchk(16'h4cc8);
    check(cke, 4'h0, "cke before init");
    idle = 15 + $urandom % 8;
    bus(1'b1, ckpd_pkg::IDLE_CFG_ADDR, 32'(idle), q);
    for (p = 0; p < 6; p++) begin
      // Arrivals stand over the policy write so the old idle count cannot fire
      act <= 4'h1;
      arrive <= 4'hf;
      slow <= p[0];
      bus(1'b1, ckpd_pkg::CTRL_ADDR, 32'(p), q);
      act <= 4'h0;
      @(posedge clk);
      arrive <= 4'h0;
      pr0 = pre_cnt;
      pc0 = pc_cnt;
      wait_bit(0, 1'b0, idle + 40, n);
      check(n < idle + 40, p != 0, "entry on expiry");
      if (p == 1) check(n > idle && n < idle + 5, 1, "idle count");
      check(pre_cnt - pr0, p == 2 || p == 3, "precharge first");
      if (p >= 4) begin
        pexp <= 4'h1;
        need(0, 1'b1);
        need(0, 1'b0);
        pexp <= 4'h0;
        check(pre_cnt - pr0, 1, "precharge on page expiry");
      end
      pend <= 4'h1;
      need(0, 1'b1);
      wait_bit(4, 1'b1, 100, n);
      if (p != 0)
        check(n >= (p[0] && p != 1 ? 19 : 2) && n < 100, 1, "exit");
      repeat (2) @(posedge clk);
      check(pc_cnt - pc0, p >= 2, "pages closed on wake");
      pend <= 4'h0;
    end
    rxv <= 4'hf;
    bus(1'b1, ckpd_pkg::RANK_CFG_ADDR, 32'h1e, q);
    @(posedge clk);
    check({cke_oe_n[0], cs_oe_n[0], drv_en[0], rx_en[0], rx_vo[0]},
          5'h18, "absent rank");
    bus(1'b1, ckpd_pkg::RANK_CFG_ADDR, 32'h1f, q);
    @(posedge clk);
    check({cke_oe_n[0], rx_vo[0]}, 2'h1, "populated rank driven");
    bus(1'b1, ckpd_pkg::CTRL_ADDR, 32'h1, q);
    need(0, 1'b0);
    need(3, 1'b0);
    ref_req <= 1'b1;
    need(5, 1'b1);
    check(cke, 4'hf, "ranks up for refresh");
    ref_req <= 1'b0;
    ref_done <= 1'b1;
    @(posedge clk);
    ref_done <= 1'b0;
    need(0, 1'b0);
    bus(1'b1, ckpd_pkg::CTRL_ADDR, 32'h11, q);
    need(6, 1'b1);
    bus(1'b0, ckpd_pkg::STATUS_ADDR, 32'h0, q);
    check(q, {14'h0, 2'h3, {4{1'b0, ckpd_pkg::ST_PD}}}, "asleep");
    check(q[16], 1, "dll off status");
    pend <= 4'h1;
    need(6, 1'b0);
    for (p = 0; p < 2; p++) begin
      pend <= 4'hf;
      need(0, 1'b1);
      need(3, 1'b1);
      pend <= 4'h0;
      sr0 = sr_cnt;
      drained <= 1'b1;
      susp <= !p[0];
      deep <= p[0];
      need(0, 1'b0);
      need(3, 1'b0);
      repeat (2) @(posedge clk);
      check(sr_cnt - sr0, 4, "self refresh entry");
      if (p == 0) susp <= 1'b0;
      else pend <= 4'h1;
      need(0, 1'b1);
      {susp, deep, pend} <= '0;
      @(posedge clk);
    end
    check(ex_cnt, 8, "self refresh exits");
    complete_run();
  end
endmodule
`default_nettype wire
